/* File: verilog/dpl_params.svh */
`ifndef DPL_PARAMS_SVH
`define DPL_PARAMS_SVH
// Serial word layout
`define DPL_ECHO_BITS 6'h20
`define DPL_CMD_BITS 6'h18
// Command codes
`define DPL_CMD_UPD_N 4'h1
`define DPL_CMD_WR_UPD_N 4'h3
`define DPL_CMD_PD_N 4'h4
`define DPL_CMD_PD_CHIP 4'h5
`define DPL_CMD_CONFIG 4'h7
`define DPL_CMD_UPD_ALL 4'h9
// Config data field bit positions
`define DPL_CFG_TS_BIT 0
`define DPL_CFG_RD_BIT 1
// Host side power-up waits after updating a powered-down channel
`define DPL_PWRUP_CHAN_US 30
`define DPL_PWRUP_CHIP_US 35
`endif

/* File: verilog/dpl_pkg.sv */
package dpl_pkg;
  typedef struct packed {
    logic [3:0] code;
    logic [3:0] addr;
    logic [15:0] data;
  } dpl_cmd_t;
  typedef logic [3:0] dpl_chan_t;
endpackage

/* File: verilog/dpl_ctrl.sv */
// Notes on behaviour
// R1 - During each transfer the previous 32-bit instruction is echoed on sdo.
// R2 - Sdo is released whenever select_and_load_n is high.
// R3 - Power-down never alters input or DAC register contents.
// R4 - Channel power-down command powers down the addressed channel.
// R5 - Chip power-down command powers down all channels and the reference.
// R6 - Power-down commands ignore their data field.
// R7 - Any update of a powered-down channel brings it back up.
// R8 - Host waits 30us or 35us after such an update for valid output.
// R9 - Load pin low with select high copies all input to DAC registers.
// R10 - Load pulse inside a frame powers up outputs without any update.
// R11 - Load pin low at frame end: run command, then update all outputs.
// R12 - Load pin low powers up all outputs regardless of select.
// R13 - Load pin low at frame end blocks power-down and external reference.
// R14 - Reference-disable bit resets to 0, written by config command.
// R15 - Reference-disable set to 1 turns off the internal reference.
// R16 - Thermal protection off bit is written by config command.
// R17 - Update-all command updates every channel like the load pin.
// R18 - Per-channel and chip powered-down flags kept, cleared by updates.
`timescale 1ns/1ns
`include "dpl_params.svh"
module dpl_ctrl
  import dpl_pkg::*;
(
  input wire logic clk_sys, // 250 MHz system clock
  input wire logic rstn, // Async reset, active low
  input wire logic sck, // Serial clock pin
  input wire logic sdi, // Serial data in pin
  input wire logic select_and_load_n, // Frame select and load pin
  input wire logic async_update_n, // Asynchronous load pin
  output logic sdo_o, // Serial echo data
  output logic sdo_oe, // High while sdo is driven
  output dpl_cmd_t cmd_o, // Executed instruction word
  output logic cmd_valid_o, // One-cycle strobe with cmd_o
  output dpl_chan_t dac_update_o, // Copy input to DAC register, per channel
  output dpl_chan_t chan_pd_o, // Channel powered down
  output logic chip_pd_o, // Whole chip powered down
  output logic ref_disable_o, // Internal reference disabled
  output logic ref_off_o, // Internal reference powered off
  output logic thermal_protect_off_bit_o // Overtemperature guard off
);
  // Pins are sampled by sys clock; sck must stay below about 30 MHz
  logic [1:0] sck_sync_reg, sdi_sync_reg, cs_sync_reg, ld_sync_reg;
  logic sck_prev_reg, cs_prev_reg;
  logic [31:0] shift_reg;
  logic [5:0] bitcnt_reg;
  logic pend_upd_reg;
  logic sdo_reg, sdo_oe_reg, chip_pd_reg, rd_reg, ts_reg, valid_reg;
  logic ref_off_reg;
  dpl_cmd_t cmd_reg;
  dpl_chan_t upd_reg, pd_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sck_sync_reg <= 2'h0;
      sdi_sync_reg <= 2'h0;
      cs_sync_reg <= 2'h3;
      ld_sync_reg <= 2'h3;
      sck_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      sck_sync_reg <= {sck_sync_reg[0], sck};
      sdi_sync_reg <= {sdi_sync_reg[0], sdi};
      cs_sync_reg <= {cs_sync_reg[0], select_and_load_n};
      ld_sync_reg <= {ld_sync_reg[0], async_update_n};
      sck_prev_reg <= sck_sync_reg[1];
      cs_prev_reg <= cs_sync_reg[1];
    end
  end

  logic cs_hi, ld_low, frame_start, frame_end, sck_rise, sck_fall, exec;
  dpl_cmd_t word;
  assign cs_hi = cs_sync_reg[1];
  assign ld_low = !ld_sync_reg[1];
  assign frame_start = !cs_hi && cs_prev_reg;
  assign frame_end = cs_hi && !cs_prev_reg;
  assign sck_rise = !cs_hi && sck_sync_reg[1] && !sck_prev_reg;
  assign sck_fall = !cs_hi && !sck_sync_reg[1] && sck_prev_reg;
  assign word = shift_reg[23:0];
  // Short frames are dropped rather than run with stale bits
  assign exec = frame_end && (bitcnt_reg >= `DPL_CMD_BITS);

  logic is_pd_n, is_pd_chip, is_cfg, is_upd_n, is_upd_all, suppress;
  assign is_pd_n = word.code == `DPL_CMD_PD_N;
  assign is_pd_chip = word.code == `DPL_CMD_PD_CHIP;
  assign is_cfg = word.code == `DPL_CMD_CONFIG;
  assign is_upd_n = word.code == `DPL_CMD_UPD_N ||
                    word.code == `DPL_CMD_WR_UPD_N;
  assign is_upd_all = word.code == `DPL_CMD_UPD_ALL;
  assign suppress = ld_low; // R13

  // Shift register keeps the last word, so shifting a new one echoes it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shift_reg <= 32'h0000_0000;
      bitcnt_reg <= 6'h00;
    end else if (frame_start) begin
      bitcnt_reg <= 6'h00;
    end else if (sck_rise) begin
      shift_reg <= {shift_reg[30:0], sdi_sync_reg[1]}; // R1
      if (bitcnt_reg != `DPL_ECHO_BITS)
        bitcnt_reg <= bitcnt_reg + 6'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sdo_reg <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end else begin
      sdo_oe_reg <= !cs_hi; // R2
      if (frame_start || sck_fall)
        sdo_reg <= shift_reg[31]; // R1
    end
  end

  // Level update runs a cycle after frame end so the command lands first
  logic lvl_upd;
  dpl_chan_t upd_vec;
  assign lvl_upd = (cs_hi && ld_low && !frame_end) || pend_upd_reg; // R9 R11
  always_comb begin
    upd_vec = 4'h0;
    if (exec && is_upd_n)
      upd_vec = 4'h1 << word.addr[1:0];
    if (lvl_upd || (exec && is_upd_all)) // R17
      upd_vec = 4'hf;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pend_upd_reg <= 1'b0;
      upd_reg <= 4'h0;
      cmd_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      pend_upd_reg <= frame_end && ld_low; // R11
      upd_reg <= upd_vec;
      valid_reg <= exec;
      if (exec)
        cmd_reg <= word;
    end
  end

  // Flags only gate power; stored codes stay with the downstream registers
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
      logic pd_set;
      assign pd_set = exec && !suppress && (is_pd_chip ||
        (is_pd_n && word.addr[1:0] == 2'(gi))); // R4 R5 R6 R3
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
          pd_reg[gi] <= 1'b0;
        else if (pd_set)
          pd_reg[gi] <= 1'b1; // R18
        else if (ld_low || upd_vec[gi])
          pd_reg[gi] <= 1'b0; // R7 R10 R12 R18
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      chip_pd_reg <= 1'b0;
    else if (exec && !suppress && is_pd_chip)
      chip_pd_reg <= 1'b1; // R5 R18
    else if (ld_low || upd_vec != 4'h0)
      chip_pd_reg <= 1'b0; // R7 R12
  end

  // A blocked config write is dropped whole to keep both bits coherent
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_reg <= 1'b0; // R14
      ts_reg <= 1'b0;
      ref_off_reg <= 1'b0;
    end else begin
      if (exec && is_cfg && !(suppress && word.data[`DPL_CFG_RD_BIT])) begin
        rd_reg <= word.data[`DPL_CFG_RD_BIT]; // R14 R15 R13
        ts_reg <= word.data[`DPL_CFG_TS_BIT]; // R16
      end
      ref_off_reg <= rd_reg || chip_pd_reg; // R15 R5
    end
  end

  assign sdo_o = sdo_reg;
  assign sdo_oe = sdo_oe_reg;
  assign cmd_o = cmd_reg;
  assign cmd_valid_o = valid_reg;
  assign dac_update_o = upd_reg;
  assign chan_pd_o = pd_reg;
  assign chip_pd_o = chip_pd_reg;
  assign ref_disable_o = rd_reg;
  assign ref_off_o = ref_off_reg;
  assign thermal_protect_off_bit_o = ts_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_sdo_release: assert property (cs_hi |=> !sdo_oe) // R2
    else $error("sdo driven while select high");
  // Each detected fall must present the bit that the last rise exposed
  a_echo_shift: assert property (sck_fall // R1
    |=> sdo_o == $past(shift_reg[31]))
    else $error("echo order broken");
  a_chan_pd_set: assert property (exec && ld_sync_reg[1] && is_pd_n // R4
    |=> chan_pd_o[$past(word.addr[1:0])])
    else $error("channel not powered down");
  a_chip_pd_all: assert property (exec && ld_sync_reg[1] // R5 R6
    && is_pd_chip |=> chip_pd_o && chan_pd_o == 4'hf
    && rd_reg == $past(rd_reg))
    else $error("chip power-down incomplete");
  a_load_pwrup: assert property (ld_low // R12 R13 R10
    |=> !chip_pd_o && chan_pd_o == 4'h0)
    else $error("load pin did not power up");
  a_load_update: assert property (cs_hi && ld_low && !frame_end // R9
    |=> dac_update_o == 4'hf)
    else $error("level load did not update");
  a_frame_load: assert property (frame_end && ld_low // R11
    |=> ##1 dac_update_o == 4'hf)
    else $error("frame load update missing");
  a_upd_clears: assert property (dac_update_o != 4'h0 // R7
    |-> (dac_update_o & chan_pd_o) == 4'h0)
    else $error("updated channel still down");
  a_cfg_write: assert property (exec && is_cfg && ld_sync_reg[1] // R14 R15
    |=> rd_reg == $past(word.data[`DPL_CFG_RD_BIT]) ##1
        ref_off_o == $past(rd_reg || chip_pd_reg))
    else $error("config write lost");

  c_chip_pd: cover property (exec && is_pd_chip ##[1:40] ld_low);
  c_cfg_ext: cover property (exec && is_cfg && word.data[1] && !ld_low);
  c_pulse_in_frame: cover property (!cs_hi && ld_low ##[1:40] frame_end);
  c_upd_all: cover property (exec && is_upd_all);
endmodule

/* File: verif/dpl_host.sv */
`timescale 1ns/1ns
`include "dpl_params.svh"
module dpl_host (
  input wire logic clk_sys, // System clock
  input wire logic sdo_o, // Echo from device
  input wire logic sdo_oe, // Echo drive enable
  output logic sck, // Serial clock
  output logic sdi, // Serial data
  output logic select_and_load_n, // Frame select
  output logic async_update_n // Load pin
);
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
    select_and_load_n = 1'b1;
    async_update_n = 1'b1;
  end
  localparam int CYC_PER_US = 250; // 4 ns clock
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Mode 0 plain, 1 load pulse mid-frame, 2 load held over frame end
  task automatic xfer(input logic [31:0] w, input int mode,
                      output logic [31:0] echo);
    select_and_load_n = 1'b0;
    tick(6);
    for (int i = 31; i >= 0; i--) begin
      sdi = w[i];
      // Settled three cycles after the last fall; pull-up when released
      echo[i] = sdo_oe ? sdo_o : 1'b1;
      sck = 1'b1;
      tick(6);
      sck = 1'b0;
      tick(6);
      if (mode == 1 && i == 16) begin
        load_pulse();
      end
    end
    if (mode == 2) begin
      async_update_n = 1'b0;
      tick(4);
    end
    select_and_load_n = 1'b1;
    sdi = ~sdi; // Released line must not keep the last bit
    // Load let go one cycle later, so only the frame-end path updates
    tick(1);
    async_update_n = 1'b1;
    tick(13);
  endtask
  task automatic load_pulse();
    async_update_n = 1'b0;
    tick(4);
    async_update_n = 1'b1;
    tick(6);
  endtask
  // Settling time after waking a channel or the whole chip
  task automatic pwrup_wait(input logic chip);
    tick(chip ? `DPL_PWRUP_CHIP_US * CYC_PER_US
              : `DPL_PWRUP_CHAN_US * CYC_PER_US);
  endtask
endmodule

/* File: verif/test_dpl_ctrl.sv */
`timescale 1ns/1ns
`include "dpl_params.svh"
module test_dpl_ctrl;
  import dpl_pkg::*;
  logic clk_sys, rstn, sck, sdi, select_and_load_n, async_update_n;
  logic sdo_o, sdo_oe, cmd_valid_o, chip_pd_o, ref_disable_o, ref_off_o;
  logic ts_o, have;
  dpl_cmd_t cmd_o;
  dpl_chan_t dac_update_o, chan_pd_o, seen, pd_seen;
  logic [31:0] last;
  logic [23:0] got_cmd;
  int n_fail, checks, n_valid;
  dpl_ctrl uut (.clk_sys(clk_sys), .rstn(rstn), .sck(sck), .sdi(sdi),
    .select_and_load_n(select_and_load_n), .async_update_n(async_update_n),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o),
    .dac_update_o(dac_update_o), .chan_pd_o(chan_pd_o), .chip_pd_o(chip_pd_o),
    .ref_disable_o(ref_disable_o), .ref_off_o(ref_off_o),
    .thermal_protect_off_bit_o(ts_o));
  dpl_host host (.clk_sys(clk_sys), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .sck(sck), .sdi(sdi),
    .select_and_load_n(select_and_load_n), .async_update_n(async_update_n));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Sampled on the falling edge, away from the design's update edge
  // Short power-down blips and one-cycle strobes are caught here too
  always @(negedge clk_sys) begin
    seen = seen | dac_update_o;
    pd_seen = pd_seen | chan_pd_o;
    if (cmd_valid_o) begin
      n_valid++;
      got_cmd = cmd_o;
    end
  end
  task automatic chk(input string name, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic close_out();
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic send(input logic [3:0] c, a, input logic [15:0] d,
                      input int mode);
    logic [31:0] w, e;
    w = {8'h00, c, a, d};
    seen = 4'h0;
    pd_seen = 4'h0;
    n_valid = 0;
    host.xfer(w, mode, e);
    if (have) chk("echo", e, last);
    chk("sdo_oe", sdo_oe, 1'b0);
    chk("cmd_valid", n_valid, 1);
    chk("cmd_o", got_cmd, w[23:0]);
    last = w;
    have = 1'b1;
  endtask
  task automatic t_chan_pd();
    send(`DPL_CMD_PD_N, 4'h2, 16'hFFFF, 0);
    chk("chan_pd", chan_pd_o, 4'h4);
    chk("no_upd", seen, 4'h0);
    send(`DPL_CMD_UPD_N, 4'h2, 16'h0000, 0);
    chk("upd_n", seen, 4'h4);
    chk("chan_pd", chan_pd_o, 4'h0);
    host.pwrup_wait(1'b0);
  endtask
  task automatic t_chip_pd();
    send(`DPL_CMD_PD_CHIP, 4'h0, 16'h1234, 0);
    chk("chan_pd", chan_pd_o, 4'hF);
    chk("chip_pd", chip_pd_o, 1'b1);
    chk("ref_off", ref_off_o, 1'b1);
    seen = 4'h0;
    host.load_pulse();
    chk("ld_upd", seen, 4'hF);
    chk("pd_clr", {chip_pd_o, chan_pd_o}, 5'h00);
    host.pwrup_wait(1'b1);
  endtask
  task automatic t_config();
    send(`DPL_CMD_CONFIG, 4'h0, 16'h0003, 0);
    chk("rd", ref_disable_o, 1'b1);
    chk("ref_off", ref_off_o, 1'b1);
    chk("ts", ts_o, 1'b1);
    send(`DPL_CMD_CONFIG, 4'h0, 16'h0000, 0);
    chk("rd", {ref_disable_o, ts_o}, 2'b00);
  endtask
  task automatic t_ld_end();
    send(`DPL_CMD_PD_N, 4'h1, 16'h0000, 2);
    chk("pd_block", chan_pd_o, 4'h0);
    chk("pd_blip", pd_seen, 4'h0);
    chk("end_upd", seen, 4'hF);
    send(`DPL_CMD_CONFIG, 4'h0, 16'h0002, 2);
    chk("rd_block", ref_disable_o, 1'b0);
  endtask
  task automatic t_ld_mid();
    send(`DPL_CMD_PD_CHIP, 4'h0, 16'h0000, 0);
    send(4'hF, 4'h0, 16'h0000, 1);
    chk("pd_clr", {chip_pd_o, chan_pd_o}, 5'h00);
    chk("no_upd", seen, 4'h0);
  endtask
  task automatic t_upd_all();
    send(`DPL_CMD_PD_N, 4'h3, 16'h0000, 0);
    send(`DPL_CMD_UPD_ALL, 4'h0, 16'h0000, 0);
    chk("upd_all", seen, 4'hF);
    chk("chan_pd", chan_pd_o, 4'h0);
  endtask
  initial begin
    rstn = 1'b0;
    have = 1'b0;
    seen = 4'h0;
    pd_seen = 4'h0;
    n_valid = 0;
    got_cmd = 24'h00_0000;
    last = 32'h0000_0000;
    n_fail = 0;
    checks = 0;
    repeat (4) @(posedge clk_sys);
    #1 rstn = 1'b1;
    host.tick(5);
    chk("rd_rst", ref_disable_o, 1'b0);
    chk("oe_rst", sdo_oe, 1'b0);
    t_chan_pd();
    t_chip_pd();
    t_config();
    t_ld_end();
    t_ld_mid();
    t_upd_all();
    close_out();
  end
endmodule
